//--- design/ofd_operand_decoder.v
// Chosen here: the register addresses and the APB interface to the registers.
`timescale 1ns/10ps
`include "ofd_map.vh"
// How it works
// RULE1: access bit 0 maps file address into fixed access region, bank pointer ignored.
// RULE2: access bit 1 forms address from bank pointer and 8-bit file field.
// RULE3: destination bit 0 writes accumulator, 1 writes the addressed file register.
// RULE4: three-bit field selects bit 0 to 7 of the addressed byte.
// RULE5: file field is 8-bit address, or 2-bit pointer selector for pointer loads.
// RULE6: move operands are full 12-bit addresses without the bank pointer.
// RULE7: literals are extracted as 8, 12 or 20 bits by format.
// RULE8: relative branches add signed offset to counter; calls and gotos jump direct.
// RULE9: fast bit 1 saves or restores shadow copies; 0 leaves them alone.
// RULE10: table accesses apply none, post-increment, post-decrement or pre-increment.
// RULE11: table pointer is 21 bits; table data passes an 8-bit latch.
// RULE12: indexed forms add 7-bit source and destination offsets to a pointer.
// RULE13: arithmetic keeps carry, nibble carry, zero, signed wrap and negative flags.
// RULE14: 8-by-8 multiply result lands in high and low product bytes.
// RULE15: counter low byte is exposed; high and upper holding bytes load on write.
// RULE16: don't-care bits have no effect on behaviour.
// RULE17: a lone second word with top nibble ones acts as no-operation.
// RULE18: one cycle normally; an extra no-operation cycle on counter change or two words.
// RULE19: field extraction is combinational from the fetched word.
module ofd_operand_decoder (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  output wire [11:0] dec_ram_addr,
  output wire [7:0]  dec_bit_mask,
  output wire        dec_to_file,
  output wire        exec_busy
);
  // ==========================================================
  // states
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_EXEC = 2'h1;
  localparam [1:0] ST_NOP  = 2'h2;

  reg  [15:0] instr_reg;
  reg  [15:0] instr2_reg;
  reg  [7:0]  accumulator_reg;
  reg  [3:0]  bank_pointer_reg;
  reg  [20:0] program_memory_pointer_reg;
  reg  [7:0]  program_read_latch_reg;
  reg  [7:0]  multiply_result_high_reg;
  reg  [7:0]  multiply_result_low_reg;
  reg  [20:0] pc_reg;
  reg  [7:0]  pc_high_holding_reg;
  reg  [4:0]  pc_upper_holding_reg;
  reg  [4:0]  flags_reg;
  reg  [7:0]  ctrl_reg;
  reg  [7:0]  opnd_reg;
  reg  [11:0] indirect_pointer_reg [0:3];
  reg  [20:0] wb_reg;
  reg  [7:0]  shadow_acc_reg;
  reg  [4:0]  shadow_flags_reg;
  reg  [3:0]  shadow_bank_reg;
  reg  [1:0]  state_reg;
  reg  [1:0]  state_next;
  reg  [31:0] prdata_reg;
  reg         pready_reg;
  reg         pslverr_reg;
  reg  [11:0] dec_ram_addr_reg;
  reg  [7:0]  dec_bit_mask_reg;
  reg         dec_to_file_reg;
  reg         busy_reg;

  wire [11:0] ram_addr;
  wire        to_file;
  wire [7:0]  bit_mask;
  wire [7:0]  lit8;
  wire [11:0] lit12;
  wire [19:0] lit20;
  wire [20:0] rel_off;
  wire [1:0]  tbl_mode;
  wire        fast;
  wire [1:0]  ptr_sel;
  wire [11:0] src_addr;
  wire [11:0] dst_addr;
  wire [6:0]  src_off;
  wire [6:0]  dst_off;
  wire        lone_second;

  wire [2:0]  fmt = ctrl_reg[`OFD_CTRL_FMT_HI:0];

  ofd_field_decode u_field (
    .word_first   (instr_reg),
    .word_second  (instr2_reg),
    .bank         (bank_pointer_reg),
    .fmt          (fmt),
    .short_branch (ctrl_reg[`OFD_CTRL_SHORT]),
    .ram_addr     (ram_addr),
    .to_file      (to_file),
    .bit_mask     (bit_mask),
    .lit8         (lit8),
    .lit12        (lit12),
    .lit20        (lit20),
    .rel_off      (rel_off),
    .tbl_mode     (tbl_mode),
    .fast         (fast),
    .ptr_sel      (ptr_sel),
    .src_addr     (src_addr),
    .dst_addr     (dst_addr),
    .src_off      (src_off),
    .dst_off      (dst_off),
    .lone_second  (lone_second)
  );

  // ==========================================================
  // arithmetic: accumulator plus operand
  wire [8:0]  sum9    = {1'b0, accumulator_reg} + {1'b0, opnd_reg};
  wire [4:0]  nib5    = {1'b0, accumulator_reg[3:0]} + {1'b0, opnd_reg[3:0]};
  wire [7:0]  sum8    = sum9[7:0];
  wire        wrap    = (accumulator_reg[7] == opnd_reg[7]) && (sum8[7] != accumulator_reg[7]);
  wire [4:0]  new_flags = {sum8[7], wrap, (sum8 == 8'h00), nib5[4], sum9[8]};        // [RULE13]
  wire [15:0] product = accumulator_reg * opnd_reg;                                  // [RULE14]

  wire [11:0] idx_src = indirect_pointer_reg[2] + {5'h00, src_off};                  // [RULE12]
  wire [11:0] idx_dst = indirect_pointer_reg[2] + {5'h00, dst_off};                  // [RULE12]

  wire [20:0] pc_step = pc_reg + 21'h000002;
  wire [20:0] pc_rel  = pc_step + {rel_off[19:0], 1'b0};                             // [RULE8]
  wire [20:0] tp_inc  = program_memory_pointer_reg + 21'h000001;
  wire [20:0] tp_dec  = program_memory_pointer_reg - 21'h000001;

  wire        apb_acc = psel && penable && !pready_reg;
  wire        apb_wr  = apb_acc && pwrite;
  wire        go      = apb_wr && (paddr == `OFD_OFF_INSTR) && (state_reg == ST_IDLE);
  wire        two_word = (fmt == `OFD_FMT_MOVE) || (fmt == `OFD_FMT_JUMP) || (fmt == `OFD_FMT_PTR);
  wire        pc_jump = !lone_second &&
                        ((fmt == `OFD_FMT_JUMP) || (fmt == `OFD_FMT_REL));

  // ==========================================================
  // sequencer
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (go)
          state_next = ST_EXEC;
      end
      ST_EXEC:
      begin
        // the burned cycle behaves as a no-operation [RULE18]
        state_next = (pc_jump || (two_word && !lone_second)) ? ST_NOP : ST_IDLE;
      end
      ST_NOP:
        state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  integer i;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg                  <= ST_IDLE;
      busy_reg                   <= 1'b0;
      instr_reg                  <= 16'h0000;
      instr2_reg                 <= 16'h0000;
      accumulator_reg            <= `OFD_RST_BYTE;
      bank_pointer_reg           <= 4'h0;
      program_memory_pointer_reg <= `OFD_RST_PC;
      program_read_latch_reg     <= `OFD_RST_BYTE;
      multiply_result_high_reg   <= `OFD_RST_BYTE;
      multiply_result_low_reg    <= `OFD_RST_BYTE;
      pc_reg                     <= `OFD_RST_PC;
      pc_high_holding_reg        <= `OFD_RST_BYTE;
      pc_upper_holding_reg       <= 5'h00;
      flags_reg                  <= 5'h00;
      ctrl_reg                   <= `OFD_RST_BYTE;
      opnd_reg                   <= `OFD_RST_BYTE;
      wb_reg                     <= 21'h000000;
      shadow_acc_reg             <= `OFD_RST_BYTE;
      shadow_flags_reg           <= 5'h00;
      shadow_bank_reg            <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        indirect_pointer_reg[i] <= 12'h000;
    end
    else
    begin
      state_reg <= state_next;
      busy_reg  <= (state_next != ST_IDLE);
      // register writes; execution effects below take precedence
      if (apb_wr)
      begin
        case (paddr)
          `OFD_OFF_INSTR:  if (state_reg == ST_IDLE) instr_reg <= pwdata[15:0];
          `OFD_OFF_INSTR2: if (state_reg == ST_IDLE) instr2_reg <= pwdata[15:0];
          `OFD_OFF_ACC:    accumulator_reg <= pwdata[7:0];
          `OFD_OFF_BANK:   bank_pointer_reg <= pwdata[3:0];
          `OFD_OFF_TPTR:   program_memory_pointer_reg <= pwdata[20:0];              // [RULE11]
          `OFD_OFF_TLAT:   program_read_latch_reg <= pwdata[7:0];                    // [RULE11]
          `OFD_OFF_PROD:
          begin
            multiply_result_low_reg  <= pwdata[7:0];
            multiply_result_high_reg <= pwdata[15:8];
          end
          `OFD_OFF_PC:
          begin
            // one write loads the holding bytes and all of pc_reg from pwdata [RULE15]
            pc_high_holding_reg  <= pwdata[15:8];
            pc_upper_holding_reg <= pwdata[20:16];
            pc_reg               <= {pwdata[20:16], pwdata[15:8], pwdata[7:0]};
          end
          `OFD_OFF_STATUS: flags_reg <= pwdata[4:0];
          `OFD_OFF_CTRL:   ctrl_reg <= pwdata[7:0];
          `OFD_OFF_OPND:   opnd_reg <= pwdata[7:0];
          default:         ;
        endcase
      end
      // a lone second word changes nothing but the counter [RULE17]
      if (state_reg == ST_EXEC && lone_second)
        pc_reg <= pc_step;
      else if (state_reg == ST_EXEC)
      begin
        pc_reg <= two_word ? pc_step + 21'h000002 : pc_step;
        case (fmt)
          `OFD_FMT_BYTE:
          begin
            if (ctrl_reg[`OFD_CTRL_MUL])
            begin
              multiply_result_high_reg <= product[15:8];                             // [RULE14]
              multiply_result_low_reg  <= product[7:0];                              // [RULE14]
            end
            else
            begin
              if (ctrl_reg[`OFD_CTRL_FLAGS])
                flags_reg <= new_flags;                                              // [RULE13]
              if (to_file)
                wb_reg <= {1'b1, ram_addr, sum8};                                    // [RULE3]
              else
                accumulator_reg <= sum8;                                             // [RULE3]
            end
          end
          `OFD_FMT_BIT:
            wb_reg <= {1'b1, ram_addr, opnd_reg ^ bit_mask};                         // [RULE4]
          `OFD_FMT_LIT:
            accumulator_reg <= lit8;                                                 // [RULE7]
          `OFD_FMT_MOVE:
            wb_reg <= {1'b1, dst_addr, opnd_reg};                                    // [RULE6]
          `OFD_FMT_JUMP:
          begin
            if (ctrl_reg[`OFD_CTRL_RET])
            begin
              pc_reg <= {1'b0, lit20};
              if (fast)
              begin
                accumulator_reg  <= shadow_acc_reg;                                  // [RULE9]
                flags_reg        <= shadow_flags_reg;                                // [RULE9]
                bank_pointer_reg <= shadow_bank_reg;                                 // [RULE9]
              end
            end
            else
            begin
              pc_reg <= {lit20, 1'b0};                                               // [RULE8]
              if (fast)
              begin
                shadow_acc_reg   <= accumulator_reg;                                 // [RULE9]
                shadow_flags_reg <= flags_reg;                                       // [RULE9]
                shadow_bank_reg  <= bank_pointer_reg;                                // [RULE9]
              end
            end
          end
          `OFD_FMT_REL:
            pc_reg <= pc_rel;                                                        // [RULE8]
          `OFD_FMT_TABLE:
          begin
            if (!ctrl_reg[`OFD_CTRL_TWR])
              program_read_latch_reg <= opnd_reg;                                    // [RULE11]
            case (tbl_mode)
              `OFD_TM_POSTINC: program_memory_pointer_reg <= tp_inc;                 // [RULE10]
              `OFD_TM_POSTDEC: program_memory_pointer_reg <= tp_dec;                 // [RULE10]
              `OFD_TM_PREINC:  program_memory_pointer_reg <= tp_inc;                 // [RULE10]
              default:         ;
            endcase
          end
          `OFD_FMT_PTR:
            indirect_pointer_reg[ptr_sel] <= lit12;                                  // [RULE5]
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // apb slave: one wait state, unmapped reads zero with error
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_reg  <= 32'h00000000;
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else
    begin
      pready_reg  <= apb_acc;
      pslverr_reg <= 1'b0;
      prdata_reg  <= 32'h00000000;
      if (apb_acc)
      begin
        case (paddr)
          `OFD_OFF_INSTR:  prdata_reg <= {16'h0000, instr_reg};
          `OFD_OFF_INSTR2: prdata_reg <= {16'h0000, instr2_reg};
          `OFD_OFF_ACC:    prdata_reg <= {24'h000000, accumulator_reg};
          `OFD_OFF_BANK:   prdata_reg <= {28'h0000000, bank_pointer_reg};
          `OFD_OFF_TPTR:   prdata_reg <= {11'h000, program_memory_pointer_reg};
          `OFD_OFF_TLAT:   prdata_reg <= {24'h000000, program_read_latch_reg};
          `OFD_OFF_PROD:   prdata_reg <= {16'h0000, multiply_result_high_reg, multiply_result_low_reg};
          `OFD_OFF_PC:     prdata_reg <= {11'h000, pc_upper_holding_reg, pc_high_holding_reg, pc_reg[7:0]};
          `OFD_OFF_STATUS: prdata_reg <= {23'h000000, busy_reg, 3'h0, flags_reg};
          `OFD_OFF_DEC:    prdata_reg <= {8'h00, fast, tbl_mode, to_file, bit_mask, ram_addr};
          `OFD_OFF_IDX:    prdata_reg <= {8'h00, idx_dst, idx_src};
          `OFD_OFF_CTRL:   prdata_reg <= {24'h000000, ctrl_reg};
          `OFD_OFF_OPND:   prdata_reg <= {24'h000000, opnd_reg};
          `OFD_OFF_PTR0:   prdata_reg <= {20'h00000, indirect_pointer_reg[0]};
          `OFD_OFF_PTR1:   prdata_reg <= {20'h00000, indirect_pointer_reg[1]};
          `OFD_OFF_PTR2:   prdata_reg <= {20'h00000, indirect_pointer_reg[2]};
          `OFD_OFF_PTR3:   prdata_reg <= {20'h00000, indirect_pointer_reg[3]};
          `OFD_OFF_WB:     prdata_reg <= {11'h000, wb_reg};
          default:         pslverr_reg <= 1'b1;
        endcase
        // a write answers with zero data
        if (pwrite)
          prdata_reg <= 32'h00000000;
      end
    end
  end

  // ==========================================================
  // decoded fields, refreshed every cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dec_ram_addr_reg <= 12'h000;
      dec_bit_mask_reg <= 8'h00;
      dec_to_file_reg  <= 1'b0;
    end
    else
    begin
      dec_ram_addr_reg <= ram_addr;                                                  // [RULE1] [RULE2]
      dec_bit_mask_reg <= bit_mask;
      dec_to_file_reg  <= to_file;
    end
  end

  assign prdata       = prdata_reg;
  assign pready       = pready_reg;
  assign pslverr      = pslverr_reg;
  assign dec_ram_addr = dec_ram_addr_reg;
  assign dec_bit_mask = dec_bit_mask_reg;
  assign dec_to_file  = dec_to_file_reg;
  assign exec_busy    = busy_reg;
endmodule // ofd_operand_decoder

//--- design/ofd_map.vh
`ifndef OFD_MAP_VH
`define OFD_MAP_VH
// ==========================================================
// register byte offsets
`define OFD_OFF_INSTR   12'h000
`define OFD_OFF_INSTR2  12'h004
`define OFD_OFF_ACC     12'h008
`define OFD_OFF_BANK    12'h00c
`define OFD_OFF_TPTR    12'h010
`define OFD_OFF_TLAT    12'h014
`define OFD_OFF_PROD    12'h018
`define OFD_OFF_PC      12'h01c
`define OFD_OFF_STATUS  12'h020
`define OFD_OFF_DEC     12'h024
`define OFD_OFF_IDX     12'h028
`define OFD_OFF_CTRL    12'h02c
`define OFD_OFF_OPND    12'h030
`define OFD_OFF_PTR0    12'h034
`define OFD_OFF_PTR1    12'h038
`define OFD_OFF_PTR2    12'h03c
`define OFD_OFF_PTR3    12'h040
`define OFD_OFF_WB      12'h044
// ==========================================================
// field positions
`define OFD_ST_C        0
`define OFD_ST_DC       1
`define OFD_ST_Z        2
`define OFD_ST_OV       3
`define OFD_ST_N        4
`define OFD_ST_BUSY     8
`define OFD_CTRL_FMT_HI 2
`define OFD_CTRL_FLAGS  3
`define OFD_CTRL_MUL    4
`define OFD_CTRL_RET    5
`define OFD_CTRL_TWR    6
`define OFD_CTRL_SHORT  7
// ==========================================================
// operand formats
`define OFD_FMT_BYTE    3'h0
`define OFD_FMT_BIT     3'h1
`define OFD_FMT_LIT     3'h2
`define OFD_FMT_MOVE    3'h3
`define OFD_FMT_JUMP    3'h4
`define OFD_FMT_REL     3'h5
`define OFD_FMT_TABLE   3'h6
`define OFD_FMT_PTR     3'h7
// ==========================================================
// table pointer modes
`define OFD_TM_NONE     2'h0
`define OFD_TM_POSTINC  2'h1
`define OFD_TM_POSTDEC  2'h2
`define OFD_TM_PREINC   2'h3
// ==========================================================
// reset values and constants
`define OFD_RST_BYTE    8'h00
`define OFD_RST_PC      21'h000000
`define OFD_ACCESS_SPLIT 8'h60
`define OFD_SECOND_TAG  4'hf
`endif

//--- design/ofd_field_decode.v
`timescale 1ns/10ps
`include "ofd_map.vh"
// ==========================================================
// pure field extraction from the fetched words
module ofd_field_decode (
  input  wire [15:0] word_first,
  input  wire [15:0] word_second,
  input  wire [3:0]  bank,
  input  wire [2:0]  fmt,
  input  wire        short_branch,
  output reg  [11:0] ram_addr,
  output reg         to_file,
  output reg  [7:0]  bit_mask,
  output reg  [7:0]  lit8,
  output reg  [11:0] lit12,
  output reg  [19:0] lit20,
  output reg  [20:0] rel_off,
  output reg  [1:0]  tbl_mode,
  output reg         fast,
  output reg  [1:0]  ptr_sel,
  output reg  [11:0] src_addr,
  output reg  [11:0] dst_addr,
  output reg  [6:0]  src_off,
  output reg  [6:0]  dst_off,
  output reg         lone_second
);
  always @*
  begin
    // unused bits are never looked at, so either value acts the same [RULE16] [RULE19]
    if (word_first[8])
      ram_addr = {bank, word_first[7:0]};                                            // [RULE2]
    else if (word_first[7:0] < `OFD_ACCESS_SPLIT)
      ram_addr = {4'h0, word_first[7:0]};                                            // [RULE1]
    else
      ram_addr = {4'hf, word_first[7:0]};                                            // [RULE1]
    to_file     = word_first[9];                                                     // [RULE3]
    bit_mask    = 8'h01 << word_first[11:9];                                         // [RULE4]
    lit8        = word_first[7:0];                                                   // [RULE7]
    lit12       = {word_first[3:0], word_second[7:0]};                               // [RULE7]
    lit20       = {word_second[11:0], word_first[7:0]};                              // [RULE7] [RULE8]
    if (short_branch)
      rel_off = {{13{word_first[7]}}, word_first[7:0]};                              // [RULE8]
    else
      rel_off = {{10{word_first[10]}}, word_first[10:0]};                            // [RULE8]
    tbl_mode    = word_first[1:0];                                                   // [RULE10]
    fast        = word_first[0];                                                     // [RULE9]
    ptr_sel     = (fmt == `OFD_FMT_PTR) ? word_first[5:4] : 2'h0;                    // [RULE5]
    src_addr    = word_first[11:0];                                                  // [RULE6]
    dst_addr    = word_second[11:0];                                                 // [RULE6]
    src_off     = word_first[6:0];                                                   // [RULE12]
    dst_off     = word_second[6:0];                                                  // [RULE12]
    lone_second = (word_first[15:12] == `OFD_SECOND_TAG);                            // [RULE17]
  end
endmodule // ofd_field_decode

//--- sim/ofd_operand_decoder_asserts.sv
`timescale 1ns/10ps
// ==========================================================
// port checks, apb timing and decoded outputs
module ofd_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  input wire [11:0] dec_ram_addr,
  input wire [7:0]  dec_bit_mask,
  input wire        dec_to_file,
  input wire        exec_busy
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_acc;
    psel && penable;
  endsequence
  a_one_wait: assert property (s_setup ##1 s_acc |-> !pready ##1 pready)
    else $error("pready not after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_rdata_quiet: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside a read answer");
  a_err_unmapped: assert property (pready && paddr > 12'h044 |-> pslverr)
    else $error("unmapped access without error");
  a_err_mapped: assert property (pready && paddr <= 12'h044 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on a mapped register");
  a_no_req: assert property (!psel |-> !pready && !pslverr)
    else $error("answer without a request");
  a_mask_onehot: assert property ($onehot0(dec_bit_mask))
    else $error("bit mask not one-hot");
  a_file_bit: assert property ($onehot(dec_bit_mask) |-> dec_to_file == |(dec_bit_mask & 8'haa))
    else $error("destination bit disagrees with mask");
  a_busy_start: assert property ((s_acc and (pready && pwrite && paddr == 12'h000 && !$past(exec_busy)))
                                 |-> exec_busy)
    else $error("instruction write did not start execution");
  a_busy_max: assert property (exec_busy ##1 exec_busy |=> !exec_busy)
    else $error("execution longer than two cycles");
endmodule // ofd_chk

bind ofd_operand_decoder ofd_chk i_ofd_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .dec_ram_addr(dec_ram_addr), .dec_bit_mask(dec_bit_mask), .dec_to_file(dec_to_file), .exec_busy(exec_busy));

//--- sim/test_ofd_operand_decoder.sv
`timescale 1ns/10ps
`include "ofd_map.vh"
module test_ofd_operand_decoder;
  reg         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  reg  [11:0] paddr = 0;
  reg  [31:0] pwdata = 0;
  wire [31:0] prdata;
  wire        pready, pslverr, dec_to_file, exec_busy;
  wire [11:0] dec_ram_addr;
  wire [7:0]  dec_bit_mask;
  integer     err_total = 0, tests_run = 0, i;
  reg  [32:0] q[$];
  reg  [31:0] a, b, e;
  reg  [15:0] w, w2;
  reg  [8:0]  s;
  reg  [3:0]  bk;
  always #5 pclk = ~pclk;
  ofd_operand_decoder i_ofd_operand_decoder (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dec_ram_addr(dec_ram_addr), .dec_bit_mask(dec_bit_mask), .dec_to_file(dec_to_file), .exec_busy(exec_busy));
  // ==========================================================
  // checking and closing
  task summarize;
    if (err_total == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input [32:0] got, input [32:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // oldest note is matched to each completed transfer
  always @(posedge pclk)
    if (psel && penable && pready)
      chk({pslverr, prdata}, q.pop_front());
  // ==========================================================
  // apb master
  task xfer(input wr, input [11:0] ad, input [31:0] d, input [32:0] ex);
    integer n;
    begin
      q.push_back(ex);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do
      begin
        @(posedge pclk);
        n = n + 1;
      end
      while (pready !== 1'b1 && n < 20);
      psel <= 0;
      penable <= 0;
      if (n >= 20)
      begin
        chk(0, 1);
        summarize;
      end
    end
  endtask
  task wr(input [11:0] ad, input [31:0] d);
    xfer(1, ad, d, 0);
  endtask
  task rd(input [11:0] ad, input [31:0] ex);
    xfer(0, ad, 0, {1'b0, ex});
  endtask
  // busy lasts at most two cycles, so four is always enough
  task ex(input [15:0] iw);
    begin
      wr(`OFD_OFF_INSTR, iw);
      chk(exec_busy, 1);
      repeat (4) @(posedge pclk);
      chk(exec_busy, 0);
    end
  endtask
  function [11:0] ram(input [15:0] iw, input [3:0] bank);
    if (iw[8])
      ram = {bank, iw[7:0]};
    else
      ram = (iw[7:0] < 8'h60) ? {4'h0, iw[7:0]} : {4'hf, iw[7:0]};
  endfunction
  // ==========================================================
  // main sequence
  initial
  begin
    a = $urandom(68890);
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(`OFD_OFF_ACC, 0);
    rd(`OFD_OFF_BANK, 0);
    rd(`OFD_OFF_TPTR, 0);
    rd(`OFD_OFF_PC, 0);
    rd(`OFD_OFF_STATUS, 0);
    rd(`OFD_OFF_PROD, 0);
    xfer(0, 12'h048, 0, {1'b1, 32'h0});
    xfer(1, 12'h0f0, 32'hffffffff, {1'b1, 32'h0});
    for (i = 0; i < 24; i = i + 1)
    begin
      bk = $urandom;
      w = $urandom;
      w2 = $urandom;
      // both sides of the access split
      if (i < 2)
        w[8:0] = {1'b0, 8'h5f + i[7:0]};
      wr(`OFD_OFF_BANK, bk);
      wr(`OFD_OFF_INSTR2, w2);
      ex(w);
      e = ram(w, bk);
      chk({dec_to_file, dec_bit_mask, dec_ram_addr}, {w[9], 8'h01 << w[11:9], e[11:0]});
      rd(`OFD_OFF_DEC, {8'h0, w[0], w[1:0], w[9], 8'h01 << w[11:9], e[11:0]});
      rd(`OFD_OFF_IDX, {8'h0, 5'h0, w2[6:0], 5'h0, w[6:0]});
    end
    wr(`OFD_OFF_CTRL, 8'h08);
    for (i = 0; i < 4; i = i + 1)
    begin
      a = (i == 0) ? 8'hff : $urandom & 8'hff;
      b = (i == 0) ? 8'h01 : $urandom & 8'hff;
      s = a + b;
      wr(`OFD_OFF_ACC, a);
      wr(`OFD_OFF_OPND, b);
      ex(16'h2410 | (i[0] << 9));
      if (i[0])
        rd(`OFD_OFF_WB, {11'h0, 1'b1, 12'h010, s[7:0]});
      rd(`OFD_OFF_ACC, i[0] ? a : s[7:0]);
      e = {s[7], (a[7] == b[7]) && (s[7] != a[7]), s[7:0] == 0, a[3:0] + b[3:0] > 15, s[8]};
      rd(`OFD_OFF_STATUS, e);
    end
    wr(`OFD_OFF_CTRL, 8'h10);
    wr(`OFD_OFF_ACC, a);
    wr(`OFD_OFF_OPND, b);
    ex(16'h0210);
    rd(`OFD_OFF_PROD, a * b);
    wr(`OFD_OFF_CTRL, 8'h06);
    for (i = 0; i < 4; i = i + 1)
    begin
      wr(`OFD_OFF_TPTR, 21'h1fffff);
      wr(`OFD_OFF_OPND, 8'h5a + i);
      ex(16'h0008 | i[1:0]);
      rd(`OFD_OFF_TPTR, (i == 0) ? 21'h1fffff : (i == 2) ? 21'h1ffffe : 21'h0);
      rd(`OFD_OFF_TLAT, 8'h5a + i);
    end
    wr(`OFD_OFF_CTRL, 0);
    wr(`OFD_OFF_PC, 0);
    wr(`OFD_OFF_ACC, 8'h33);
    ex(16'hf123);
    rd(`OFD_OFF_PC, 2);
    rd(`OFD_OFF_ACC, 8'h33);
    wr(`OFD_OFF_CTRL, 8'h05);
    wr(`OFD_OFF_PC, 32'h100);
    ex(16'hd7fe);
    rd(`OFD_OFF_PC, 32'h0001fe);
    // pointer load, then indexed sums from the loaded pointer
    wr(`OFD_OFF_CTRL, 8'h07);
    wr(`OFD_OFF_INSTR2, 16'h0034);
    ex(16'hee2c);
    rd(`OFD_OFF_PTR2, 12'hc34);
    rd(`OFD_OFF_IDX, {8'h0, 12'hc68, 12'hc60});
    wr(`OFD_OFF_CTRL, 8'h02);
    ex(16'h0e5a);
    rd(`OFD_OFF_ACC, 8'h5a);
    wr(`OFD_OFF_CTRL, 8'h03);
    wr(`OFD_OFF_OPND, 8'ha5);
    wr(`OFD_OFF_INSTR2, 16'hf9c3);
    ex(16'hc123);
    rd(`OFD_OFF_WB, 32'h0019c3a5);
    wr(`OFD_OFF_CTRL, 8'h01);
    ex(16'h8a42);
    rd(`OFD_OFF_WB, 32'h00104285);
    // fast call saves, plain call leaves the copy, fast return restores
    wr(`OFD_OFF_CTRL, 8'h04);
    wr(`OFD_OFF_ACC, 8'h77);
    wr(`OFD_OFF_INSTR2, 16'hf012);
    ex(16'hec35);
    rd(`OFD_OFF_PC, 32'h00016a);
    wr(`OFD_OFF_ACC, 8'h11);
    ex(16'hec34);
    wr(`OFD_OFF_CTRL, 8'h24);
    ex(16'hec01);
    rd(`OFD_OFF_ACC, 8'h77);
    summarize;
  end
endmodule // test_ofd_operand_decoder
